// ===== logic/gpd_top.sv
`timescale 1ns/1ns
module gpd_top #(
    parameter bit HAS_THIRD_PORT = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_master_clear,
    input wire logic [gpd_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_rd_en,
    input wire logic i_wr_en,
    input wire logic [gpd_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_bit_op_en,
    input wire logic [gpd_pkg::BIT_IDX_W-1:0] i_bit_idx,
    input wire logic i_bit_val,
    input wire logic i_dir_load,
    output logic [gpd_pkg::DATA_W-1:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic [gpd_pkg::FIRST_W-1:0] i_first_port_pins,
    output logic [gpd_pkg::FIRST_W-1:0] o_first_port_pins_out,
    output logic [gpd_pkg::FIRST_W-1:0] o_first_port_pins_oe,
    input wire logic [gpd_pkg::DATA_W-1:0] i_second_port_pins,
    output logic [gpd_pkg::DATA_W-1:0] o_second_port_out,
    output logic [gpd_pkg::DATA_W-1:0] o_second_port_oe,
    input wire logic [gpd_pkg::DATA_W-1:0] i_third_port_pins,
    output logic [gpd_pkg::DATA_W-1:0] o_third_port_out,
    output logic [gpd_pkg::DATA_W-1:0] o_third_port_oe
);
    localparam int DW = gpd_pkg::DATA_W;
    localparam int FW = gpd_pkg::FIRST_W;

    logic sel_first;
    logic sel_second;
    logic sel_third;
    logic [DW-1:0] pins_first;
    logic [DW-1:0] pins_third;
    logic [DW-1:0] cur_pins;
    logic [DW-1:0] bit_mask;
    logic [DW-1:0] rmw_data;
    logic [DW-1:0] port_wr_data;
    logic [DW-1:0] rd_data_q;
    logic rd_valid_q;

    gpd_port_if #(.W(FW)) first_if ();
    gpd_port_if #(.W(DW)) second_if ();

    assign sel_first = (i_addr == gpd_pkg::FIRST_PORT_ADDR);
    assign sel_second = (i_addr == gpd_pkg::SECOND_PORT_ADDR);
    assign sel_third = (i_addr == gpd_pkg::THIRD_PORT_ADDR);

    // unimplemented upper bits of the first port read as zero
    assign pins_first = {{(DW-FW){1'b0}}, i_first_port_pins};

    // pin levels of the addressed port, taken live with no input latch
    always_comb begin
        cur_pins = gpd_pkg::READ_ZERO;
        if (sel_first) begin
            cur_pins = pins_first;
        end else if (sel_second) begin
            cur_pins = i_second_port_pins;
        end else if (sel_third) begin
            cur_pins = pins_third;
        end
    end

    // bit set/clear works on the pin levels, so input pins overwrite their latches
    assign bit_mask = gpd_pkg::BIT_ONE << i_bit_idx;
    assign rmw_data = i_bit_val ? (cur_pins | bit_mask) : (cur_pins & ~bit_mask);
    assign port_wr_data = i_bit_op_en ? rmw_data : i_wr_data;

    // write and direction strobes towards the first and second port banks
    assign first_if.wr_en = (i_wr_en || i_bit_op_en) && sel_first;
    assign first_if.wr_data = port_wr_data[FW-1:0];
    assign first_if.dir_ld = i_dir_load && sel_first;
    assign first_if.dir_data = i_wr_data[FW-1:0];
    assign second_if.wr_en = (i_wr_en || i_bit_op_en) && sel_second;
    assign second_if.wr_data = port_wr_data;
    assign second_if.dir_ld = i_dir_load && sel_second;
    assign second_if.dir_data = i_wr_data;

    gpd_port_bank #(.W(FW)) u_first (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_master_clear(i_master_clear),
        .p(first_if.bank)
    );

    gpd_port_bank #(.W(DW)) u_second (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_master_clear(i_master_clear),
        .p(second_if.bank)
    );

    assign o_first_port_pins_out = first_if.latch;
    assign o_first_port_pins_oe = first_if.oe;
    assign o_second_port_out = second_if.latch;
    assign o_second_port_oe = second_if.oe;

    // third address: a real port on the larger variant, a data register otherwise
    generate
        if (HAS_THIRD_PORT) begin : g_third_port
            gpd_port_if #(.W(DW)) third_if ();
            assign third_if.wr_en = (i_wr_en || i_bit_op_en) && sel_third;
            assign third_if.wr_data = port_wr_data;
            assign third_if.dir_ld = i_dir_load && sel_third;
            assign third_if.dir_data = i_wr_data;
            gpd_port_bank #(.W(DW)) u_third (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_master_clear(i_master_clear),
                .p(third_if.bank)
            );
            assign pins_third = i_third_port_pins;
            assign o_third_port_out = third_if.latch;
            assign o_third_port_oe = third_if.oe;
        end else begin : g_third_reg
            logic [DW-1:0] gp_q;
            logic [DW-1:0] idle_q;
            // plain storage: written value reads back, pins stay floated
            always_ff @(posedge i_clk) begin
                if ((i_wr_en || i_bit_op_en) && sel_third) begin
                    gp_q <= port_wr_data;
                end
            end
            always_ff @(posedge i_clk) begin
                idle_q <= gpd_pkg::READ_ZERO;
            end
            assign pins_third = gp_q;
            assign o_third_port_out = idle_q;
            assign o_third_port_oe = idle_q;

            gp_reg_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
                i_wr_en && !i_bit_op_en && sel_third |=> gp_q == $past(i_wr_data))
                else $error("general purpose register lost its write");
        end
    endgenerate

    // read data is captured at the end of the cycle from the pins themselves
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_data_q <= gpd_pkg::READ_ZERO;
        end else if (i_rd_en) begin
            rd_data_q <= cur_pins;
        end
    end

    // one-cycle marker that read data is valid
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en;
        end
    end

    assign o_rd_data = rd_data_q;
    assign o_rd_valid = rd_valid_q;

    rd_pins_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_rd_en && sel_second |=> o_rd_valid && o_rd_data == $past(i_second_port_pins))
        else $error("second port read did not return pin levels");

    dir_reset_a: assert property (@(posedge i_clk)
        i_sys_rst |=> o_second_port_oe == gpd_pkg::READ_ZERO && o_first_port_pins_oe == '0)
        else $error("pins not floated after reset");

    first_upper_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_rd_en && sel_first |=> o_rd_data[DW-1:FW] == '0
            && o_rd_data[FW-1:0] == $past(i_first_port_pins))
        else $error("first port read wrong");

    dir_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_master_clear)
        i_dir_load && sel_second && !$past(i_master_clear) |=> o_second_port_oe == ~$past(i_wr_data))
        else $error("direction load not applied");

    wr_latch_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_wr_en && !i_bit_op_en && sel_second |=> o_second_port_out == $past(i_wr_data))
        else $error("port write not latched at cycle end");

    latch_hold_a: assert property (@(posedge i_clk)
        !((i_wr_en || i_bit_op_en) && sel_second) |=> $stable(o_second_port_out))
        else $error("output latch changed without a write");

    rmw_bit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_bit_op_en && sel_second |=> o_second_port_out ==
            (($past(i_second_port_pins) & ~(gpd_pkg::BIT_ONE << $past(i_bit_idx)))
            | ({{(DW-1){1'b0}}, $past(i_bit_val)} << $past(i_bit_idx))))
        else $error("bit set or clear wrote wrong latch value");

    master_clear_keep_a: assert property (@(posedge i_clk)
        i_master_clear && !((i_wr_en || i_bit_op_en) && sel_first) |=> $stable(o_first_port_pins_out)
            ##0 o_first_port_pins_oe == '0)
        else $error("master clear disturbed first port latch");

    dir_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_master_clear)
        !(i_dir_load && sel_second) && !$past(i_sys_rst) |=> $stable(o_second_port_oe))
        else $error("direction changed without a load");
endmodule

// ===== logic/gpd_pkg.sv
package gpd_pkg;
    // file addresses decoded by the port block
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int FIRST_W = 4;
    localparam int BIT_IDX_W = 3;
    localparam logic [ADDR_W-1:0] FIRST_PORT_ADDR = 5'h05;
    localparam logic [ADDR_W-1:0] SECOND_PORT_ADDR = 5'h06;
    localparam logic [ADDR_W-1:0] THIRD_PORT_ADDR = 5'h07;
    // reset and read-back values, and the seed for the bit mask
    localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
endpackage

// ===== logic/gpd_port_if.sv
`timescale 1ns/1ns
interface gpd_port_if #(
    parameter int W = 8
);
    logic wr_en;
    logic [W-1:0] wr_data;
    logic dir_ld;
    logic [W-1:0] dir_data;
    logic [W-1:0] latch;
    logic [W-1:0] oe;

    modport bank (
        input wr_en,
        input wr_data,
        input dir_ld,
        input dir_data,
        output latch,
        output oe
    );
    modport ctrl (
        output wr_en,
        output wr_data,
        output dir_ld,
        output dir_data,
        input latch,
        input oe
    );
endinterface

// ===== logic/gpd_port_bank.sv
`timescale 1ns/1ns
module gpd_port_bank #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_master_clear,
    gpd_port_if.bank p
);
    logic [W-1:0] dir_q;
    logic [W-1:0] dir_d;
    logic [W-1:0] latch_q;
    logic [W-1:0] oe_q;

    // direction is write-only: only the load strobe, a reset or a master clear changes it
    always_comb begin
        dir_d = dir_q;
        if (i_sys_rst || i_master_clear) begin
            dir_d = gpd_pkg::DIR_RESET[W-1:0];
        end else if (p.dir_ld) begin
            dir_d = p.dir_data;
        end
    end

    always_ff @(posedge i_clk) begin
        dir_q <= dir_d;
    end

    // enable kept as its own flop so the pin driver comes straight from a register
    always_ff @(posedge i_clk) begin
        oe_q <= ~dir_d;
    end

    // latch has no reset: left unknown at power-on, kept through master clear
    always_ff @(posedge i_clk) begin
        if (p.wr_en) begin
            latch_q <= p.wr_data;
        end
    end

    assign p.latch = latch_q;
    assign p.oe = oe_q;
endmodule

// ===== tb/gpd_pin_model.sv
`timescale 1ns/1ns
// external circuitry on one port; an external driver overpowers the pin driver
module gpd_pin_model #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_ext_en,
    input wire logic [W-1:0] i_ext_val,
    output logic [W-1:0] o_pin
);
    logic [W-1:0] float_q = '0;
    // a floating pin flips every cycle so a stale level never passes for data
    always @(posedge i_clk) begin
        float_q <= ~o_pin;
    end
    // external level wins a fight, which is how a held-low driven-high pin reads
    assign o_pin = (i_ext_en & i_ext_val) | (~i_ext_en & i_oe & i_out)
        | (~i_ext_en & ~i_oe & float_q);
endmodule

// ===== tb/tb_gpd_top.sv
`timescale 1ns/1ns
module tb_gpd_top;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_master_clear = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic i_rd_en = 1'b0, i_wr_en = 1'b0, i_bit_op_en = 1'b0, i_dir_load = 1'b0;
    logic [7:0] i_wr_data = 8'h00;
    logic [2:0] i_bit_idx = 3'h0;
    logic i_bit_val = 1'b0;
    logic [7:0] o_rd_data, b_pin, b_out, b_oe, c_pin, c_out, c_oe;
    logic o_rd_valid;
    logic [3:0] a_pin, a_out, a_oe;
    logic [3:0] a_en = 4'h0, a_val = 4'h0;
    logic [7:0] b_en = 8'h00, b_val = 8'h00, c_en = 8'h00, c_val = 8'h00;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    always #2 i_clk = ~i_clk;
    gpd_top gpd_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_master_clear(i_master_clear),
        .i_addr(i_addr), .i_rd_en(i_rd_en), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data),
        .i_bit_op_en(i_bit_op_en), .i_bit_idx(i_bit_idx), .i_bit_val(i_bit_val),
        .i_dir_load(i_dir_load), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .i_first_port_pins(a_pin), .o_first_port_pins_out(a_out),
        .o_first_port_pins_oe(a_oe), .i_second_port_pins(b_pin),
        .o_second_port_out(b_out), .o_second_port_oe(b_oe),
        .i_third_port_pins(c_pin), .o_third_port_out(c_out), .o_third_port_oe(c_oe));
    gpd_pin_model #(.W(4)) gpd_pin_model_i (.i_clk(i_clk), .i_oe(a_oe), .i_out(a_out),
        .i_ext_en(a_en), .i_ext_val(a_val), .o_pin(a_pin));
    gpd_pin_model gpd_pin_model_b (.i_clk(i_clk), .i_oe(b_oe), .i_out(b_out),
        .i_ext_en(b_en), .i_ext_val(b_val), .o_pin(b_pin));
    gpd_pin_model gpd_pin_model_c (.i_clk(i_clk), .i_oe(c_oe), .i_out(c_out),
        .i_ext_en(c_en), .i_ext_val(c_val), .o_pin(c_pin));
    logic [7:0] g_rd_data, g_c_out, g_c_oe;
    logic g_rd_valid;
    // a second build without the third port, where 07h is plain storage
    if (1) begin : g_gp
        gpd_top #(.HAS_THIRD_PORT(1'b0)) gpd_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
            .i_master_clear(i_master_clear), .i_addr(i_addr), .i_rd_en(i_rd_en), .i_wr_en(i_wr_en),
            .i_wr_data(i_wr_data), .i_bit_op_en(i_bit_op_en), .i_bit_idx(i_bit_idx),
            .i_bit_val(i_bit_val), .i_dir_load(i_dir_load), .o_rd_data(g_rd_data),
            .o_rd_valid(g_rd_valid), .i_first_port_pins(a_pin), .o_first_port_pins_out(),
            .o_first_port_pins_oe(), .i_second_port_pins(b_pin), .o_second_port_out(),
            .o_second_port_oe(), .i_third_port_pins(c_pin), .o_third_port_out(g_c_out),
            .o_third_port_oe(g_c_oe));
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one instruction: strobe up for a single sampling edge, outputs settled after
    task automatic cyc(input logic [3:0] kind, input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        {i_rd_en, i_wr_en, i_bit_op_en, i_dir_load} = kind;
        i_addr = a;
        i_wr_data = d;
        i_bit_idx = d[2:0];
        i_bit_val = d[7];
        @(posedge i_clk);
        #1;
        {i_rd_en, i_wr_en, i_bit_op_en, i_dir_load} = 4'h0;
    endtask
    task automatic t_reset();
        chk({a_oe, 4'h0} | b_oe | c_oe, 8'h00);
    endtask
    task automatic t_second();
        b_en = 8'h0f;
        b_val = 8'h06;
        cyc(4'h4, 5'h06, 8'ha5);
        cyc(4'h1, 5'h06, 8'h0f);
        chk(b_oe, 8'hf0);
        chk(b_out, 8'ha5);
        cyc(4'h8, 5'h06, 8'h00);
        chk(o_rd_data, 8'ha6);
        chk({7'h00, o_rd_valid}, 8'h01);
        b_en = 8'hff;
        b_val = 8'h5a;
        cyc(4'h8, 5'h06, 8'h00);
        chk(o_rd_data, 8'h5a);
        cyc(4'h1, 5'h06, 8'hff);
        chk(b_oe, 8'h00);
        chk(b_out, 8'ha5);
    endtask
    // bit ops copy input pin levels into the latch of every other bit
    task automatic t_rmw();
        b_val = 8'h41;
        cyc(4'h2, 5'h06, 8'h85);
        chk(b_out, 8'h61);
        cyc(4'h2, 5'h06, 8'h00);
        chk(b_out, 8'h40);
    endtask
    task automatic t_first();
        a_en = 4'hf;
        a_val = 4'h9;
        cyc(4'h4, 5'h05, 8'hff);
        chk({4'h0, a_out}, 8'h0f);
        cyc(4'h8, 5'h05, 8'h00);
        chk(o_rd_data, 8'h09);
        a_en = 4'h0;
        cyc(4'h1, 5'h05, 8'h00);
        chk({4'h0, a_oe}, 8'h0f);
        cyc(4'h8, 5'h05, 8'h00);
        chk(o_rd_data, 8'h0f);
    endtask
    task automatic t_third();
        c_en = 8'hc3;
        c_val = 8'h81;
        cyc(4'h4, 5'h07, 8'h3c);
        cyc(4'h1, 5'h07, 8'hc3);
        chk(c_oe, 8'h3c);
        cyc(4'h8, 5'h07, 8'h00);
        chk(o_rd_data, 8'hbd);
        chk(g_rd_data, 8'h3c);
        chk({7'h00, g_rd_valid}, 8'h01);
        chk(g_c_out | g_c_oe, 8'h00);
        c_val = 8'h00;
        repeat (2) @(posedge i_clk);
        chk(o_rd_data, 8'hbd);
        cyc(4'h8, 5'h07, 8'h00);
        chk(o_rd_data, 8'h3c);
        cyc(4'h8, 5'h1f, 8'h00);
        chk(o_rd_data, 8'h00);
        chk(g_rd_data, 8'h00);
    endtask
    // master clear floats the pins but must leave the second and third port latches alone
    task automatic t_master_clear();
        @(posedge i_clk);
        #1;
        i_master_clear = 1'b1;
        @(posedge i_clk);
        #1;
        i_master_clear = 1'b0;
        chk({a_oe, 4'h0} | b_oe | c_oe, 8'h00);
        chk(b_out, 8'h40);
        chk(c_out, 8'h3c);
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // generous ceiling; the whole sequence needs well under a hundred cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        t_reset();
        t_second();
        t_rmw();
        t_first();
        t_third();
        t_master_clear();
        final_report();
    end
endmodule
